/* File: rtl/sts_pkg.sv */
// Constants, field layout and types for the supply, thermal and device status bank.
// Assumes a 125 MHz internal clock and a serial command port with 16-bit frames.
//
// Function
// - Power-on sets supply bit 7 (80h); soft reset leaves all zero.
// - Reserved bits always read zero and ignore clear commands.
// - Main regulator below threshold over 2 ms after switch-on sets short flag.
// - Main regulator undervoltage reset sets undervoltage flag, bit 0.
// - Aux regulator overtemp sets bit 4, undervoltage bit 3; both sticky.
// - Sleep with main regulator off: no short, overvoltage or undervoltage capture.
// - Undervoltage capture: restart only with short, init after reset release, normal, stop, short.
// - More than 16 consecutive high shutdowns set safe flag; 60 s wait follows.
// - High thermal shutdown sets thermal bit 2 and requests fail-safe mode.
// - Low thermal shutdown sets thermal bit 1, disables only affected module.
// - Thermal pre-warning sets thermal bit 0.
// - Thermal flags stay set after the condition until host clears them.
// - Pre-restart field: 00 cleared, 01 failure restart, 10 sleep, 11 unused.
// - Sleep attempt with wake flags still set reports sleep origin too.
// - Watchdog fault counter self-clears; 01 fails config 2, 10 others.
// - Configs 2 and 4 hold counter after failure until a good trigger.
// - Invalid serial command sets device bit 1; only a clear command or soft reset resets it.
// - Activation of the fail output sets device bit 0.

package sts_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [6:0] STS_ADDR_SUPPLY = 7'h41;
  localparam logic [6:0] STS_ADDR_THERM = 7'h42;
  localparam logic [6:0] STS_ADDR_DEVICE = 7'h43;
  localparam logic [7:0] STS_SUPPLY_POR_VAL = 8'h80;
  localparam logic [7:0] STS_ZERO_VAL = 8'h00;
  localparam logic [7:0] STS_SUPPLY_MASK = 8'h9D;
  localparam logic [7:0] STS_THERM_MASK = 8'h0F;
  localparam logic [7:0] STS_DEVICE_RC_MASK = 8'hC3;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int STS_BIT_POR = 7;
  localparam int STS_BIT_AUX_OT = 4;
  localparam int STS_BIT_AUX_UV = 3;
  localparam int STS_BIT_SHORT = 2;
  localparam int STS_BIT_UV = 0;
  localparam int STS_BIT_SAFE = 3;
  localparam int STS_BIT_TSD_HI = 2;
  localparam int STS_BIT_TSD_LO = 1;
  localparam int STS_BIT_TPW = 0;
  localparam int STS_BIT_SPI_FAIL = 1;
  localparam int STS_BIT_FAILURE = 0;
  localparam int STS_CMD_CLEAR_BIT = 7;
  localparam int STS_FRAME_BITS = 16;
  localparam int STS_ADDR_BITS = 8;

  localparam logic [1:0] STS_PRE_CLEARED = 2'h0;
  localparam logic [1:0] STS_PRE_FAILURE = 2'h1;
  localparam logic [1:0] STS_PRE_SLEEP = 2'h2;
  localparam logic [1:0] STS_WD_LIMIT_CFG2 = 2'h1;
  localparam logic [1:0] STS_WD_LIMIT_OTHER = 2'h2;

  // ****************************************
  // Timing
  // ****************************************
  localparam int STS_CLK_KHZ = 125000;
  localparam int STS_SHORT_TIME_MS = 2;
  localparam int STS_SHORT_CYC = STS_SHORT_TIME_MS * STS_CLK_KHZ;
  localparam longint unsigned STS_LONG_WAIT_S = 60;
  localparam longint unsigned STS_CLK_HZ = 125000000;
  localparam longint unsigned STS_LONG_WAIT_CYC = STS_LONG_WAIT_S * STS_CLK_HZ;
  localparam logic [4:0] STS_SAFE_COUNT = 5'h10;

  typedef enum logic [2:0]
  {
    STS_MODE_INIT = 3'h0,
    STS_MODE_NORMAL = 3'h1,
    STS_MODE_STOP = 3'h2,
    STS_MODE_SLEEP = 3'h3,
    STS_MODE_RESTART = 3'h4,
    STS_MODE_FAILSAFE = 3'h5
  } sts_mode_e;

endpackage

/* File: rtl/sts_cmd_if.sv */
// Carrier between the serial frame engine and the status bank.
// Assumes both ends run on the same internal clock.
`timescale 1ns/1ps

interface sts_cmd_if;
  logic cmd_valid;
  logic cmd_clear;
  logic [6:0] cmd_addr;
  logic cmd_invalid;
  logic [6:0] peek_addr;
  logic [7:0] peek_data;

  modport frame
  (
    output cmd_valid,
    output cmd_clear,
    output cmd_addr,
    output cmd_invalid,
    output peek_addr,
    input peek_data
  );
  modport bank
  (
    input cmd_valid,
    input cmd_clear,
    input cmd_addr,
    input cmd_invalid,
    input peek_addr,
    output peek_data
  );
endinterface

/* File: rtl/sts_pin_sync.sv */
// Three-stage pin synchroniser; output follows once stages two and three agree.
// Assumes inputs are asynchronous to clock.
`timescale 1ns/1ps

module sts_pin_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] out_reg;
  logic [WIDTH-1:0] out_next;

  always_comb
  begin
    out_next = out_reg;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (s2_reg[i] == s3_reg[i])
      begin
        out_next[i] = s3_reg[i];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
      out_reg <= INIT;
    end
    else
    begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign level_out = out_reg;
endmodule // sts_pin_sync

/* File: rtl/sts_spi_frame.sv */
// Serial command frame engine: 16 bits, LSB first, sampled on rising serial clock.
// Assumes synchronised pin levels; serial clock well below an eighth of clock.
`timescale 1ns/1ps

module sts_spi_frame
  import sts_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic csn_n,
  input wire logic mosi,
  output logic miso,
  sts_cmd_if.frame cmd
);
  logic sclk_q_reg;
  logic csn_q_reg;
  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  logic [7:0] cmd_reg;
  logic [7:0] cmd_next;
  logic [7:0] tx_reg;
  logic [7:0] tx_next;
  logic miso_reg;
  logic miso_next;
  logic valid_reg;
  logic invalid_reg;
  logic frame_end;

  assign frame_end = csn_n && !csn_q_reg;

  always_comb
  begin
    cnt_next = cnt_reg;
    cmd_next = cmd_reg;
    tx_next = tx_reg;
    miso_next = miso_reg;
    if (csn_n)
    begin
      cnt_next = 5'h00;
      miso_next = 1'b0;
    end
    else if (sclk && !sclk_q_reg)
    begin
      if (cnt_reg < 5'(STS_ADDR_BITS))
      begin
        cmd_next[cnt_reg[2:0]] = mosi;
      end
      if (cnt_reg != 5'h1F)
      begin
        cnt_next = cnt_reg + 5'h01;
      end
    end
    else if (!sclk && sclk_q_reg && cnt_reg >= 5'(STS_ADDR_BITS))
    begin
      // Read data is frozen before any clear of the same frame lands
      if (cnt_reg == 5'(STS_ADDR_BITS))
      begin
        tx_next = cmd.peek_data;
        miso_next = cmd.peek_data[0];
      end
      else if (cnt_reg < 5'(STS_FRAME_BITS))
      begin
        miso_next = tx_reg[cnt_reg[2:0]];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclk_q_reg <= 1'b0;
      csn_q_reg <= 1'b1;
      cnt_reg <= 5'h00;
      cmd_reg <= 8'h00;
      tx_reg <= 8'h00;
      miso_reg <= 1'b0;
      valid_reg <= 1'b0;
      invalid_reg <= 1'b0;
    end
    else
    begin
      sclk_q_reg <= sclk;
      csn_q_reg <= csn_n;
      cnt_reg <= cnt_next;
      cmd_reg <= cmd_next;
      tx_reg <= tx_next;
      miso_reg <= miso_next;
      valid_reg <= frame_end && cnt_reg == 5'(STS_FRAME_BITS);
      invalid_reg <= frame_end && cnt_reg != 5'(STS_FRAME_BITS);
    end
  end

  assign miso = miso_reg;
  assign cmd.cmd_valid = valid_reg;
  assign cmd.cmd_invalid = invalid_reg;
  assign cmd.cmd_clear = cmd_reg[STS_CMD_CLEAR_BIT];
  assign cmd.cmd_addr = cmd_reg[6:0];
  assign cmd.peek_addr = cmd_reg[6:0];
endmodule // sts_spi_frame

/* File: rtl/sts_status_bank.sv */
// Supply, thermal and device status registers behind the serial command port.
// Assumes monitor inputs are on the internal clock; serial pins are asynchronous.
`timescale 1ns/1ps

module sts_status_bank
  import sts_pkg::*;
#(
  parameter int SHORT_CYC = STS_SHORT_CYC,
  parameter longint unsigned LONG_WAIT_CYC = STS_LONG_WAIT_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic csn_n,
  input wire logic mosi,
  output logic miso,
  input wire logic soft_reset,
  input wire logic [2:0] sbc_mode,
  input wire logic main_reg_on,
  input wire logic main_below_thresh,
  input wire logic main_uv_reset_evt,
  input wire logic reset_output_low,
  input wire logic aux_ot_evt,
  input wire logic aux_uv_evt,
  input wire logic tsd_high_evt,
  input wire logic tsd_high_recovered,
  input wire logic tsd_low_evt,
  input wire logic tpw_evt,
  input wire logic [1:0] config_select_bit,
  input wire logic wd_trigger_fail,
  input wire logic wd_trigger_ok,
  input wire logic fail_release,
  input wire logic restart_exit_failure,
  input wire logic restart_exit_sleep,
  input wire logic sleep_wake_flags_set,
  output logic main_overvolt_capture_en,
  output logic fail_output,
  output logic fail_safe_req,
  output logic low_tsd_module_off,
  output logic long_wait_busy,
  output logic long_wait_done,
  output logic [7:0] supply_fail_status_b,
  output logic [7:0] thermal_protection_status,
  output logic [7:0] device_info_status
);
  // ****************************************
  // Serial port
  // ****************************************
  sts_cmd_if cmd_bus();
  logic [2:0] pin_level;

  sts_pin_sync #(.WIDTH(3), .INIT(3'h2)) u_sync
  (
    .clock(clock),
    .rst_n(rst_n),
    .pin_in({sclk, csn_n, mosi}),
    .level_out(pin_level)
  );

  sts_spi_frame u_frame
  (
    .clock(clock),
    .rst_n(rst_n),
    .sclk(pin_level[2]),
    .csn_n(pin_level[1]),
    .mosi(pin_level[0]),
    .miso(miso),
    .cmd(cmd_bus.frame)
  );

  // ****************************************
  // Register state
  // ****************************************
  localparam int SHORT_W = $clog2(SHORT_CYC + 1);
  logic [7:0] sup_reg;
  logic [7:0] sup_next;
  logic [7:0] therm_reg;
  logic [7:0] therm_next;
  logic [7:0] dev_reg;
  logic [7:0] dev_next;
  logic [SHORT_W-1:0] short_cnt_reg;
  logic [SHORT_W-1:0] short_cnt_next;
  logic [4:0] tsd_cnt_reg;
  logic [4:0] tsd_cnt_next;
  logic [33:0] wait_cnt_reg;
  logic [33:0] wait_cnt_next;
  logic fail_out_reg;
  logic fail_out_next;
  logic fail_safe_reg;
  logic low_off_reg;
  logic wait_done_reg;
  logic wait_done_next;

  logic clr_sup;
  logic clr_therm;
  logic clr_dev;
  logic main_capture_ok;
  logic short_cond;
  logic short_evt;
  logic uv_update_en;
  logic uv_set;
  logic safe_evt;
  logic [1:0] wd_limit;
  logic [1:0] wd_cnt;
  logic wd_hold_cfg;
  logic fo_activate;
  sts_mode_e mode;

  assign mode = sts_mode_e'(sbc_mode);
  assign clr_sup = cmd_bus.cmd_valid && cmd_bus.cmd_clear
    && cmd_bus.cmd_addr == STS_ADDR_SUPPLY;
  assign clr_therm = cmd_bus.cmd_valid && cmd_bus.cmd_clear
    && cmd_bus.cmd_addr == STS_ADDR_THERM;
  assign clr_dev = cmd_bus.cmd_valid && cmd_bus.cmd_clear
    && cmd_bus.cmd_addr == STS_ADDR_DEVICE;

  // ****************************************
  // Main regulator supervision
  // ****************************************
  assign main_capture_ok = !(mode == STS_MODE_SLEEP && !main_reg_on);
  assign main_overvolt_capture_en = main_capture_ok;
  assign short_cond = short_cnt_reg == SHORT_W'(SHORT_CYC);
  assign short_evt = short_cond && main_reg_on && main_below_thresh
    && main_capture_ok;
  assign uv_update_en = short_cond
    || mode == STS_MODE_NORMAL
    || mode == STS_MODE_STOP
    || (mode == STS_MODE_INIT && !reset_output_low);
  assign uv_set = main_uv_reset_evt && uv_update_en && main_capture_ok;

  always_comb
  begin
    short_cnt_next = short_cnt_reg;
    // Counts only while on and low; any recovery restarts the window
    if (!(main_reg_on && main_below_thresh))
    begin
      short_cnt_next = '0;
    end
    else if (!short_cond)
    begin
      short_cnt_next = short_cnt_reg + SHORT_W'(1);
    end
  end

  // ****************************************
  // Thermal and watchdog bookkeeping
  // ****************************************
  assign safe_evt = tsd_high_evt && tsd_cnt_reg >= STS_SAFE_COUNT;
  assign wd_limit = (config_select_bit == 2'h1) ? STS_WD_LIMIT_CFG2 : STS_WD_LIMIT_OTHER;
  assign wd_hold_cfg = config_select_bit[0];
  assign wd_cnt = dev_reg[3:2];
  assign fo_activate = (wd_trigger_fail && wd_cnt + 2'h1 == wd_limit) || tsd_high_evt;

  always_comb
  begin
    tsd_cnt_next = tsd_cnt_reg;
    wait_cnt_next = wait_cnt_reg;
    wait_done_next = 1'b0;
    fail_out_next = fail_out_reg;
    if (tsd_high_recovered)
    begin
      tsd_cnt_next = 5'h00;
    end
    if (tsd_high_evt && tsd_cnt_reg != 5'h1F)
    begin
      tsd_cnt_next = tsd_cnt_reg + 5'h01;
    end
    if (tsd_high_evt && (therm_reg[STS_BIT_SAFE] || safe_evt))
    begin
      wait_cnt_next = 34'(LONG_WAIT_CYC);
    end
    else if (wait_cnt_reg != 34'h0)
    begin
      wait_cnt_next = wait_cnt_reg - 34'h1;
      wait_done_next = wait_cnt_reg == 34'h1;
    end
    if (fail_release)
    begin
      fail_out_next = 1'b0;
    end
    if (fo_activate)
    begin
      fail_out_next = 1'b1;
    end
    if (soft_reset)
    begin
      tsd_cnt_next = 5'h00;
      wait_cnt_next = 34'h0;
      wait_done_next = 1'b0;
      fail_out_next = 1'b0;
    end
  end

  // ****************************************
  // Status registers
  // ****************************************
  always_comb
  begin
    sup_next = sup_reg;
    therm_next = therm_reg;
    dev_next = dev_reg;
    // Clears first, sets after, so a coincident event survives
    if (clr_sup)
    begin
      sup_next = 8'h00;
    end
    if (clr_therm)
    begin
      therm_next = 8'h00;
    end
    if (clr_dev)
    begin
      dev_next = dev_reg & ~STS_DEVICE_RC_MASK;
    end
    sup_next[STS_BIT_AUX_OT] = sup_next[STS_BIT_AUX_OT] | aux_ot_evt;
    sup_next[STS_BIT_AUX_UV] = sup_next[STS_BIT_AUX_UV] | aux_uv_evt;
    sup_next[STS_BIT_SHORT] = sup_next[STS_BIT_SHORT] | short_evt;
    sup_next[STS_BIT_UV] = sup_next[STS_BIT_UV] | uv_set;
    therm_next[STS_BIT_SAFE] = therm_next[STS_BIT_SAFE] | safe_evt;
    therm_next[STS_BIT_TSD_HI] = therm_next[STS_BIT_TSD_HI] | tsd_high_evt;
    therm_next[STS_BIT_TSD_LO] = therm_next[STS_BIT_TSD_LO] | tsd_low_evt;
    therm_next[STS_BIT_TPW] = therm_next[STS_BIT_TPW] | tpw_evt;
    dev_next[STS_BIT_SPI_FAIL] = dev_next[STS_BIT_SPI_FAIL] | cmd_bus.cmd_invalid;
    dev_next[STS_BIT_FAILURE] = dev_next[STS_BIT_FAILURE] | fo_activate;
    if (restart_exit_failure)
    begin
      dev_next[7:6] = STS_PRE_FAILURE;
    end
    else if (restart_exit_sleep || sleep_wake_flags_set)
    begin
      dev_next[7:6] = STS_PRE_SLEEP;
    end
    // Counter is hardware owned: host clears never touch it
    if (wd_trigger_ok)
    begin
      dev_next[3:2] = 2'h0;
    end
    else if (wd_trigger_fail && wd_cnt < wd_limit && !(wd_hold_cfg && wd_cnt != 2'h0))
    begin
      dev_next[3:2] = wd_cnt + 2'h1;
    end
    if (soft_reset)
    begin
      sup_next = STS_ZERO_VAL;
      therm_next = STS_ZERO_VAL;
      dev_next = STS_ZERO_VAL;
    end
    sup_next = sup_next & STS_SUPPLY_MASK;
    therm_next = therm_next & STS_THERM_MASK;
    dev_next = dev_next & (STS_DEVICE_RC_MASK | 8'h0C);
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sup_reg <= STS_SUPPLY_POR_VAL;
      therm_reg <= STS_ZERO_VAL;
      dev_reg <= STS_ZERO_VAL;
      short_cnt_reg <= '0;
      tsd_cnt_reg <= 5'h00;
      wait_cnt_reg <= 34'h0;
      wait_done_reg <= 1'b0;
      fail_out_reg <= 1'b0;
      fail_safe_reg <= 1'b0;
      low_off_reg <= 1'b0;
    end
    else
    begin
      sup_reg <= sup_next;
      therm_reg <= therm_next;
      dev_reg <= dev_next;
      short_cnt_reg <= short_cnt_next;
      tsd_cnt_reg <= tsd_cnt_next;
      wait_cnt_reg <= wait_cnt_next;
      wait_done_reg <= wait_done_next;
      fail_out_reg <= fail_out_next;
      fail_safe_reg <= tsd_high_evt;
      low_off_reg <= tsd_low_evt;
    end
  end

  // ****************************************
  // Read path and outputs
  // ****************************************
  always_comb
  begin
    unique case (cmd_bus.peek_addr)
      STS_ADDR_SUPPLY: cmd_bus.peek_data = sup_reg;
      STS_ADDR_THERM: cmd_bus.peek_data = therm_reg;
      STS_ADDR_DEVICE: cmd_bus.peek_data = dev_reg;
      default: cmd_bus.peek_data = 8'h00;
    endcase
  end

  assign fail_output = fail_out_reg;
  assign fail_safe_req = fail_safe_reg;
  assign low_tsd_module_off = low_off_reg;
  assign long_wait_busy = wait_cnt_reg != 34'h0;
  assign long_wait_done = wait_done_reg;
  assign supply_fail_status_b = sup_reg;
  assign thermal_protection_status = therm_reg;
  assign device_info_status = dev_reg;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  a_reserved_read_zero: assert property (
    sup_reg[6:5] == 2'h0 && !sup_reg[1] && therm_reg[7:4] == 4'h0 && dev_reg[5:4] == 2'h0)
    else $error("reserved status bit set");
  a_soft_reset_clear: assert property (
    soft_reset |=> sup_reg == 8'h00 && therm_reg == 8'h00)
    else $error("soft reset left flags");
  a_short_flag_time: assert property (
    (main_reg_on && main_below_thresh && main_capture_ok && !soft_reset
      && short_cnt_reg == SHORT_W'(SHORT_CYC - 1))
    ##1 (main_reg_on && main_below_thresh && main_capture_ok && !soft_reset)
    |=> sup_reg[STS_BIT_SHORT])
    else $error("short flag late");
  a_uv_restart_block: assert property (
    (mode == STS_MODE_RESTART && !short_cond && !sup_reg[STS_BIT_UV])
    |=> !sup_reg[STS_BIT_UV])
    else $error("undervoltage captured in restart");
  a_aux_flag_sticky: assert property (
    ((aux_ot_evt || (sup_reg[STS_BIT_AUX_OT] && !clr_sup)) && !soft_reset)
    |=> sup_reg[STS_BIT_AUX_OT])
    else $error("aux overtemp flag lost");
  a_safe_after_count: assert property (
    (tsd_high_evt && tsd_cnt_reg == STS_SAFE_COUNT && !soft_reset)
    |=> therm_reg[STS_BIT_SAFE] && long_wait_busy)
    else $error("safe flag missing after count");
  a_no_early_safe: assert property (
    (tsd_cnt_reg < STS_SAFE_COUNT && !therm_reg[STS_BIT_SAFE]) |=> !therm_reg[STS_BIT_SAFE])
    else $error("safe flag too early");
  a_tsd_high_failsafe: assert property (
    (tsd_high_evt && !soft_reset)
    |=> therm_reg[STS_BIT_TSD_HI] && fail_safe_req && fail_output)
    else $error("high shutdown not reported");
  a_thermal_set_wins: assert property (
    (clr_therm && tpw_evt && !soft_reset) |=> therm_reg[STS_BIT_TPW])
    else $error("pre-warning lost to clear");
  a_thermal_hold: assert property (
    (therm_reg[STS_BIT_TSD_LO] && !clr_therm && !soft_reset) |=> therm_reg[STS_BIT_TSD_LO])
    else $error("thermal flag dropped");
  a_wd_never_three: assert property (
    dev_reg[3:2] != 2'h3 && (config_select_bit != 2'h1 || dev_reg[3:2] != 2'h2
      || $past(config_select_bit) != 2'h1))
    else $error("watchdog counter out of range");
  a_failure_on_fo: assert property (
    $rose(fail_output) |-> dev_reg[STS_BIT_FAILURE])
    else $error("failure flag not set");
  a_spi_fail_set: assert property (
    (cmd_bus.cmd_invalid && !soft_reset) |=> dev_reg[STS_BIT_SPI_FAIL])
    else $error("invalid command not flagged");
endmodule // sts_status_bank

/* File: testbench/sts_host_model.sv */
// Host side of the serial command port: 16-bit frames, LSB first.
// Assumes the bench clock paces every pin change on its falling edge.
`timescale 1ns/1ps

module sts_host_model
(
  input wire logic clock,
  output logic sclk,
  output logic csn_n,
  output logic mosi,
  input wire logic miso
);
  initial
  begin
    sclk = 1'b0;
    csn_n = 1'b1;
    mosi = 1'b0;
  end

  // Half period of 10 clocks keeps clear of the 8-clock floor
  task automatic xfer(input logic [6:0] addr, input logic clr, input int nbits,
                      output logic [7:0] rd);
    logic [15:0] frame;
    frame = {8'h00, clr, addr};
    rd = 8'h00;
    @(negedge clock);
    csn_n = 1'b0;
    for (int i = 0; i < nbits; i++)
    begin
      mosi = frame[i];
      repeat (10) @(negedge clock);
      sclk = 1'b1;
      if (i >= 8)
      begin
        rd[i-8] = miso;
      end
      repeat (10) @(negedge clock);
      sclk = 1'b0;
    end
    repeat (10) @(negedge clock);
    csn_n = 1'b1;
    // Released line must not look held
    mosi = ~mosi;
    repeat (12) @(negedge clock);
  endtask
endmodule // sts_host_model

/* File: testbench/sts_status_bank_tb_top.sv */
// Self-checking bench for the status bank, serial host model attached.
// Assumes short counts shrunk by parameter so the run stays brief.
`timescale 1ns/1ps

`define CHK(g, e) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
      fails++; \
      $display("BAD %0t got %h want %h", $time, g, e); \
    end \
  end

module sts_status_bank_tb_top;
  import sts_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic sclk, csn_n, mosi, miso, oc_en, fail_o, fsafe, lo_off, lw_busy, lw_done;
  logic [13:0] ev = '0;
  logic [2:0] mode = STS_MODE_NORMAL;
  logic reg_on = 1'b1;
  logic below = 1'b0;
  logic rst_low = 1'b0;
  logic [1:0] cfg = 2'h0;
  logic [7:0] sup, thr, dev, rd;
  int fails = 0;
  int checks_done = 0;
  int cyc = 0;

  always #4 clock = ~clock;

  sts_host_model host (.clock(clock), .sclk(sclk), .csn_n(csn_n), .mosi(mosi), .miso(miso));

  sts_status_bank #(.SHORT_CYC(8), .LONG_WAIT_CYC(20)) dut (
    .clock(clock), .rst_n(rst_n), .sclk(sclk), .csn_n(csn_n), .mosi(mosi), .miso(miso),
    .soft_reset(ev[13]), .sbc_mode(mode), .main_reg_on(reg_on), .main_below_thresh(below),
    .main_uv_reset_evt(ev[0]), .reset_output_low(rst_low), .aux_ot_evt(ev[1]),
    .aux_uv_evt(ev[2]), .tsd_high_evt(ev[3]), .tsd_high_recovered(ev[12]),
    .tsd_low_evt(ev[4]), .tpw_evt(ev[5]), .config_select_bit(cfg), .wd_trigger_fail(ev[6]),
    .wd_trigger_ok(ev[7]), .fail_release(ev[11]), .restart_exit_failure(ev[8]),
    .restart_exit_sleep(ev[9]), .sleep_wake_flags_set(ev[10]),
    .main_overvolt_capture_en(oc_en), .fail_output(fail_o), .fail_safe_req(fsafe),
    .low_tsd_module_off(lo_off), .long_wait_busy(lw_busy), .long_wait_done(lw_done),
    .supply_fail_status_b(sup), .thermal_protection_status(thr), .device_info_status(dev));

  task automatic pulse(input logic [13:0] m);
    @(negedge clock);
    ev = m;
    @(negedge clock);
    ev = '0;
  endtask

  task automatic clr(input logic [6:0] a);
    host.xfer(a, 1'b1, 16, rd);
  endtask

  task automatic wrap_up;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Ceiling well above the expected few thousand cycles
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      fails++;
      wrap_up();
    end
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    repeat (5) @(negedge clock);
    rst_n = 1'b1;
    repeat (6) @(negedge clock);
    `CHK({sup, thr, dev}, 24'h800000)
    host.xfer(STS_ADDR_SUPPLY, 1'b0, 16, rd);
    `CHK(rd, STS_SUPPLY_POR_VAL)
    clr(STS_ADDR_SUPPLY);
    `CHK(sup, 8'h00)
    pulse(14'h0007);
    repeat (5) @(negedge clock);
    `CHK(sup, 8'h19)
    clr(STS_ADDR_SUPPLY);
    below = 1'b1;
    repeat (7) @(negedge clock);
    `CHK(sup[2], 1'b0)
    repeat (4) @(negedge clock);
    `CHK(sup[2], 1'b1)
    below = 1'b0;
    clr(STS_ADDR_SUPPLY);
    mode = STS_MODE_SLEEP;
    reg_on = 1'b0;
    below = 1'b1;
    pulse(14'h0001);
    repeat (12) @(negedge clock);
    below = 1'b0;
    `CHK({oc_en, sup}, 9'h000)
    reg_on = 1'b1;
    mode = STS_MODE_RESTART;
    pulse(14'h0001);
    `CHK(sup[0], 1'b0)
    mode = STS_MODE_INIT;
    rst_low = 1'b1;
    pulse(14'h0001);
    `CHK(sup[0], 1'b0)
    rst_low = 1'b0;
    pulse(14'h0001);
    `CHK(sup[0], 1'b1)
    clr(STS_ADDR_SUPPLY);
    mode = STS_MODE_STOP;
    pulse(14'h0001);
    `CHK(sup, 8'h01)
    clr(STS_ADDR_SUPPLY);
    // Restart blocks capture unless a short is already standing
    mode = STS_MODE_RESTART;
    below = 1'b1;
    repeat (10) @(negedge clock);
    pulse(14'h0001);
    below = 1'b0;
    `CHK(sup, 8'h05)
    mode = STS_MODE_NORMAL;
    pulse(14'h0020);
    `CHK(thr, 8'h01)
    pulse(14'h0010);
    `CHK(lo_off, 1'b1)
    pulse(14'h0008);
    `CHK(fsafe, 1'b1)
    @(negedge clock);
    `CHK({fsafe, thr, fail_o, dev[0]}, 11'h01F)
    pulse(14'h1000);
    for (int k = 0; k < 16; k++)
      pulse(14'h0008);
    `CHK(thr[3], 1'b0)
    pulse(14'h0008);
    `CHK({thr[3], lw_busy}, 2'b11)
    for (int k = 0; k < 40 && lw_done !== 1'b1; k++)
      @(negedge clock);
    `CHK(lw_done, 1'b1)
    // Pre-warning timed onto the cycle in which the clear lands
    fork
      clr(STS_ADDR_THERM);
      begin
        wait (csn_n === 1'b0);
        wait (csn_n === 1'b1);
        repeat (4) @(negedge clock);
        pulse(14'h0020);
      end
    join
    `CHK(thr, 8'h01)
    pulse(14'h0800);
    pulse(14'h0040);
    `CHK({dev[3:2], fail_o}, 3'b010)
    pulse(14'h0040);
    `CHK({dev[3:2], fail_o}, {STS_WD_LIMIT_OTHER, 1'b1})
    pulse(14'h0080);
    pulse(14'h0800);
    cfg = 2'h1;
    pulse(14'h0040);
    `CHK({dev[3:2], fail_o}, {STS_WD_LIMIT_CFG2, 1'b1})
    pulse(14'h0040);
    `CHK(dev[3:2], 2'h1)
    pulse(14'h0080);
    clr(STS_ADDR_DEVICE);
    `CHK(dev, 8'h00)
    host.xfer(STS_ADDR_DEVICE, 1'b0, 15, rd);
    host.xfer(STS_ADDR_DEVICE, 1'b0, 16, rd);
    `CHK(rd, 8'h02)
    pulse(14'h0100);
    `CHK(dev[7:6], STS_PRE_FAILURE)
    clr(STS_ADDR_DEVICE);
    `CHK(dev, 8'h00)
    pulse(14'h0200);
    `CHK(dev[7:6], STS_PRE_SLEEP)
    clr(STS_ADDR_DEVICE);
    pulse(14'h0400);
    `CHK(dev[7:6], STS_PRE_SLEEP)
    pulse(14'h0023);
    pulse(14'h2000);
    `CHK({sup, thr, dev}, 24'h000000)
    wrap_up();
  end
endmodule // sts_status_bank_tb_top
